// ===== rtl/bec_params.svh
// Offsets, field positions and codes of the bus error capture block
`ifndef BEC_PARAMS_SVH
`define BEC_PARAMS_SVH
`define BEC_OFS_SUMMARY 12'h040
`define BEC_OFS_CMDCAP 12'h740
`define BEC_OFS_MODERR 12'hC40
`define BEC_ADDR_W 12
`define BEC_DATA_W 32
`define BEC_PA_W 34
`define BEC_TAG_W 20
`define BEC_CTL_W 3
`define BEC_CMD_W 4
`define BEC_CA_W 3
`define BEC_CID_W 4
// Summary register field
`define BEC_SUM_NODE_BIT 0
// Module error source fields
`define BEC_ME_TAGADDR 0
`define BEC_ME_TAGCTL 1
`define BEC_ME_HARDERR 2
`define BEC_ME_FILL 3
`define BEC_ME_SECOND 6
`define BEC_ME_BUSCMD 7
`define BEC_ME_FILLSEC 9
`define BEC_ME_INCONS 10
`define BEC_ME_W 11
// Command capture fields
`define BEC_CAP_CID_LSB 0
`define BEC_CAP_CA_LSB 4
// Commands that perform a tag probe, one bit per command code
`define BEC_PROBE_CMD_MASK 16'h00FF
// Odd tag parity when 1
`define BEC_ODD_PARITY 1'h0
`endif

// ===== rtl/bec_pkg.sv
// Types of the bus error capture block
`include "bec_params.svh"
package bec_pkg;
  // Acknowledge pin codes at the end of an external cycle
  typedef enum logic [1:0] {
    BEC_ACK_IDLE = 2'b00,
    BEC_ACK_HARD = 2'b01,
    BEC_ACK_SOFT = 2'b10,
    BEC_ACK_OK = 2'b11
  } bec_ack_t;

  typedef struct packed {
    logic valid;
    logic isRead;
    logic [`BEC_PA_W-1:0] addr;
    logic [`BEC_TAG_W-1:0] tagAddr;
    logic tagAddrPar;
    logic [`BEC_CTL_W-1:0] tagCtl;
    logic tagCtlPar;
  } bec_probe_t;

  typedef struct packed {
    logic valid;
    logic isRead;
    logic addrParErr;
    logic ctlParErr;
    logic inconsistent;
    logic [`BEC_PA_W-1:0] addr;
    logic [`BEC_TAG_W+`BEC_CTL_W+1:0] tag;
  } bec_tagres_t;

  typedef struct packed {
    logic fillSecond;
    logic fillErr;
    logic secondErr;
    logic inconsistent;
    logic hardErr;
    logic ctlParWr;
    logic ctlParRd;
    logic addrParWr;
    logic addrParRd;
  } bec_status_t;
endpackage

// ===== rtl/bec_tag_check.sv
// Tag parity checker for backup-cache probes, one stage registered
`timescale 1ns/100ps
`include "bec_params.svh"
module bec_tag_check
  import bec_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input bec_probe_t probe,
  input wire logic cmdProbes,
  output bec_tagres_t res_r
);
  logic addrBad;
  logic ctlBad;

  // Parity over field plus stored bit, sense set by the header
  assign addrBad = probe.valid && ((^{probe.tagAddr, probe.tagAddrPar}) != `BEC_ODD_PARITY);
  assign ctlBad = probe.valid && ((^{probe.tagCtl, probe.tagCtlPar}) != `BEC_ODD_PARITY);

  // Result aligned with its address and raw tag
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      res_r <= '0;
    end else begin
      res_r.valid <= probe.valid;
      res_r.isRead <= probe.isRead;
      res_r.addrParErr <= addrBad;
      res_r.ctlParErr <= ctlBad;
      res_r.inconsistent <= (addrBad || ctlBad) && !cmdProbes;
      res_r.addr <= probe.addr;
      res_r.tag <= {probe.tagAddr, probe.tagAddrPar, probe.tagCtl, probe.tagCtlPar};
    end
  end
endmodule

// ===== rtl/bus_error_capture.sv
// Bus interface error capture, status and module error registers
`timescale 1ns/100ps
`include "bec_params.svh"
module bus_error_capture
  import bec_pkg::*;
#(
  parameter logic [15:0] PROBE_CMD_MASK = `BEC_PROBE_CMD_MASK
) (
  input wire logic sys_clk,
  input wire logic rst,
  input bec_probe_t probeIn,
  input wire logic [`BEC_CMD_W-1:0] interfaceCommand,
  input wire logic cycleDone,
  input wire logic [1:0] cycleAcknowledgePins,
  input wire logic [`BEC_PA_W-1:0] cycleAddr,
  input wire logic [`BEC_CA_W-1:0] cycleCacheState,
  input wire logic [`BEC_CID_W-1:0] cycleCommander,
  input wire logic fillErr,
  input wire logic fillEccMulti,
  input wire logic revLater,
  input wire logic statusClr,
  input wire logic tagWrEn,
  input wire logic [`BEC_TAG_W+`BEC_CTL_W+1:0] tagWrData,
  input wire logic [`BEC_ADDR_W-1:0] regAddr,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [`BEC_DATA_W-1:0] regWrData,
  output logic [`BEC_DATA_W-1:0] regRdData,
  output logic regRdValid,
  output bec_status_t interfaceStatus,
  output logic [`BEC_PA_W-1:0] interfaceAddress,
  output logic [`BEC_TAG_W+`BEC_CTL_W+1:0] probeResultTag,
  output logic tagRamWrEn,
  output logic [`BEC_TAG_W+`BEC_CTL_W+1:0] tagRamWrData,
  output logic nodeErrorSummary
);
  bec_tagres_t tagRes;
  bec_status_t status_r;
  bec_status_t status_nxt;
  logic [`BEC_PA_W-1:0] addr_r;
  logic [`BEC_TAG_W+`BEC_CTL_W+1:0] probeTag_r;
  logic [`BEC_ME_W-1:0] modErr_r;
  logic [`BEC_ME_W-1:0] modErrEv;
  logic [`BEC_ME_W-1:0] modErrClr;
  logic [`BEC_CA_W-1:0] capCa_r;
  logic [`BEC_CID_W-1:0] capCid_r;
  logic summary_r;
  logic [`BEC_DATA_W-1:0] rdData_r;
  logic rdValid_r;
  logic tagWrEn_r;
  logic [`BEC_TAG_W+`BEC_CTL_W+1:0] tagWrData_r;
  logic locked;
  logic parEv;
  logic hardEv;
  logic firstEv;
  logic fillSecEv;
  logic cmdProbes;

  assign cmdProbes = PROBE_CMD_MASK[interfaceCommand];

  bec_tag_check u_tag_check (
    .sys_clk(sys_clk),
    .rst(rst),
    .probe(probeIn),
    .cmdProbes(cmdProbes),
    .res_r(tagRes)
  );

  // A clear in the same cycle unlocks, so an arriving error is recorded as first
  assign locked = !statusClr && (status_r.addrParRd || status_r.addrParWr ||
                  status_r.ctlParRd || status_r.ctlParWr || status_r.hardErr);
  assign parEv = tagRes.addrParErr || tagRes.ctlParErr;
  assign hardEv = cycleDone && (cycleAcknowledgePins == BEC_ACK_HARD);
  assign firstEv = (parEv || hardEv) && !locked;
  // Meaning of the fill second bit follows the chip revision
  assign fillSecEv = revLater ? fillEccMulti : (fillErr && status_r.fillErr && !statusClr);

  // Status next value; set wins over a same-cycle clear
  always_comb begin
    status_nxt = statusClr ? '0 : status_r;
    if (!locked) begin
      status_nxt.addrParRd = status_nxt.addrParRd | (tagRes.addrParErr & tagRes.isRead);
      status_nxt.addrParWr = status_nxt.addrParWr | (tagRes.addrParErr & ~tagRes.isRead);
      status_nxt.ctlParRd = status_nxt.ctlParRd | (tagRes.ctlParErr & tagRes.isRead);
      status_nxt.ctlParWr = status_nxt.ctlParWr | (tagRes.ctlParErr & ~tagRes.isRead);
      status_nxt.hardErr = status_nxt.hardErr | hardEv;
      status_nxt.inconsistent = status_nxt.inconsistent | tagRes.inconsistent;
    end
    if (locked && (hardEv || parEv)) begin
      status_nxt.secondErr = 1'b1;
    end
    status_nxt.fillErr = status_nxt.fillErr | fillErr;
    status_nxt.fillSecond = status_nxt.fillSecond | fillSecEv;
  end

  // Interface status register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status_r <= '0;
    end else begin
      status_r <= status_nxt;
    end
  end

  // Address and tag capture only on a first error; later ones are dropped
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      addr_r <= '0;
      probeTag_r <= '0;
    end else if (firstEv) begin
      addr_r <= parEv ? tagRes.addr : cycleAddr;
      if (parEv) begin
        probeTag_r <= tagRes.tag;
      end
    end
  end

  // Module error source events
  always_comb begin
    modErrEv = '0;
    modErrEv[`BEC_ME_TAGADDR] = tagRes.addrParErr && !locked;
    modErrEv[`BEC_ME_TAGCTL] = tagRes.ctlParErr && !locked;
    modErrEv[`BEC_ME_HARDERR] = hardEv && !locked;
    modErrEv[`BEC_ME_FILL] = fillErr;
    modErrEv[`BEC_ME_SECOND] = locked && (hardEv || parEv);
    modErrEv[`BEC_ME_BUSCMD] = hardEv && !locked;
    modErrEv[`BEC_ME_FILLSEC] = fillSecEv;
    modErrEv[`BEC_ME_INCONS] = tagRes.inconsistent && !locked;
  end

  // Write-one-to-clear on the module error source register
  assign modErrClr = (regWr && regAddr == `BEC_OFS_MODERR) ? regWrData[`BEC_ME_W-1:0] : '0;

  // Module error source bits, set wins over clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      modErr_r <= '0;
    end else begin
      modErr_r <= (modErr_r & ~modErrClr) | modErrEv;
    end
  end

  // Command capture of a hard-error cycle that arrives while unlocked, held while its source bit stands
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      capCa_r <= '0;
      capCid_r <= '0;
    end else if (modErrEv[`BEC_ME_BUSCMD] && !modErr_r[`BEC_ME_BUSCMD]) begin
      capCa_r <= cycleCacheState;
      capCid_r <= cycleCommander;
    end
  end

  // Node summary bit, one-to-clear, set wins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      summary_r <= 1'b0;
    end else if (|modErrEv) begin
      summary_r <= 1'b1;
    end else if (regWr && regAddr == `BEC_OFS_SUMMARY && regWrData[`BEC_SUM_NODE_BIT]) begin
      summary_r <= 1'b0;
    end
  end

  // Register read port; unmapped offsets read zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdData_r <= '0;
      rdValid_r <= 1'b0;
    end else begin
      rdValid_r <= regRd;
      if (regRd) begin
        rdData_r <= '0;
        unique case (regAddr)
          `BEC_OFS_SUMMARY: begin
            rdData_r[`BEC_SUM_NODE_BIT] <= summary_r;
          end
          `BEC_OFS_CMDCAP: begin
            rdData_r[`BEC_CAP_CID_LSB +: `BEC_CID_W] <= capCid_r;
            rdData_r[`BEC_CAP_CA_LSB +: `BEC_CA_W] <= capCa_r;
          end
          `BEC_OFS_MODERR: begin
            rdData_r[`BEC_ME_W-1:0] <= modErr_r;
          end
          default: begin
            rdData_r <= '0;
          end
        endcase
      end
    end
  end

  // Tag write path, registered toward the tag RAM
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tagWrEn_r <= 1'b0;
      tagWrData_r <= '0;
    end else begin
      tagWrEn_r <= tagWrEn;
      if (tagWrEn) begin
        tagWrData_r <= tagWrData;
      end
    end
  end

  // Outputs straight from flops
  assign regRdData = rdData_r;
  assign regRdValid = rdValid_r;
  assign interfaceStatus = status_r;
  assign interfaceAddress = addr_r;
  assign probeResultTag = probeTag_r;
  assign tagRamWrEn = tagWrEn_r;
  assign tagRamWrData = tagWrData_r;
  assign nodeErrorSummary = summary_r;
endmodule

// ===== verification/bec_checker.sv
// Port-level assertions for the bus error capture block
`timescale 1ns/100ps
`include "bec_params.svh"
module bec_checker
  import bec_pkg::*;
#(
  parameter logic [15:0] PROBE_CMD_MASK = `BEC_PROBE_CMD_MASK
) (
  input wire logic sys_clk,
  input wire logic rst,
  input bec_probe_t probeIn,
  input wire logic [3:0] interfaceCommand,
  input wire logic cycleDone,
  input wire logic [1:0] cycleAcknowledgePins,
  input wire logic statusClr,
  input wire logic tagWrEn,
  input wire logic [24:0] tagWrData,
  input bec_status_t interfaceStatus,
  input wire logic [33:0] interfaceAddress,
  input wire logic [24:0] probeResultTag,
  input wire logic tagRamWrEn,
  input wire logic [24:0] tagRamWrData,
  input wire logic nodeErrorSummary
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic lock;
  logic hard;
  logic aBad;
  logic cBad;
  logic isProbe;
  // Locked while a capture bit is set and no clear arrives this cycle
  assign lock = (|interfaceStatus[4:0]) && !statusClr;
  assign hard = cycleDone && (cycleAcknowledgePins == BEC_ACK_HARD);
  assign aBad = probeIn.valid && (^{probeIn.tagAddr, probeIn.tagAddrPar});
  assign cBad = probeIn.valid && (^{probeIn.tagCtl, probeIn.tagCtlPar});
  assign isProbe = PROBE_CMD_MASK[interfaceCommand];
  // Probe result lands one cycle after the probe is taken
  sequence s_first(bad); bad && isProbe ##1 !lock; endsequence
  sequence s_late(bad); bad && isProbe ##1 lock; endsequence
  property p_addrRd; s_first(aBad && probeIn.isRead) |=> interfaceStatus.addrParRd
    && interfaceAddress == $past(probeIn.addr, 2); endproperty
  a_addrRd: assert property (p_addrRd) else $error("address parity capture wrong");
  property p_ctlWr; s_first(cBad && !probeIn.isRead) |=> interfaceStatus.ctlParWr
    && probeResultTag[3:0] == {$past(probeIn.tagCtl, 2), $past(probeIn.tagCtlPar, 2)};
  endproperty
  a_ctlWr: assert property (p_ctlWr) else $error("control parity capture wrong");
  property p_hard2; lock && hard |=> interfaceStatus.secondErr; endproperty
  a_hard2: assert property (p_hard2) else $error("hard error under lock missed");
  property p_probe2; s_late(aBad || cBad) |=> interfaceStatus.secondErr; endproperty
  a_probe2: assert property (p_probe2) else $error("probe error under lock missed");
  property p_hold; lock |=> $stable(interfaceAddress) && $stable(probeResultTag); endproperty
  a_hold: assert property (p_hold) else $error("captured state moved");
  property p_incons; (aBad || cBad) && !isProbe ##1 !lock |=> interfaceStatus.inconsistent;
  endproperty
  a_incons: assert property (p_incons) else $error("inconsistent flag missed");
  property p_tagWr; tagWrEn |=> tagRamWrEn && tagRamWrData == $past(tagWrData); endproperty
  a_tagWr: assert property (p_tagWr) else $error("tag write not passed on");
  property p_sum; $rose(|interfaceStatus) |-> nodeErrorSummary; endproperty
  a_sum: assert property (p_sum) else $error("summary bit not set");
endmodule
bind bus_error_capture bec_checker #(.PROBE_CMD_MASK(PROBE_CMD_MASK)) u_chk (.sys_clk, .rst,
  .probeIn, .interfaceCommand, .cycleDone, .cycleAcknowledgePins, .statusClr, .tagWrEn,
  .tagWrData, .interfaceStatus, .interfaceAddress, .probeResultTag, .tagRamWrEn,
  .tagRamWrData, .nodeErrorSummary);

// ===== verification/bec_bus_model.sv
// Behavioural tag RAM answering backup-cache probes
`timescale 1ns/100ps
module bec_bus_model
  import bec_pkg::*;
(
  input wire logic sys_clk,
  input wire logic req,
  input wire logic isRd,
  input wire logic [33:0] addr,
  input wire logic [1:0] flip,
  input wire logic ramWrEn,
  input wire logic [24:0] ramWrData,
  output bec_probe_t probe
);
  logic [24:0] tag_r = 25'h0;
  // Tag RAM takes corrected tags from software
  always @(posedge sys_clk) begin
    if (ramWrEn) tag_r <= ramWrData;
  end
  // Idle lines invert so no stale probe data looks valid; flip injects bad parity
  always @(posedge sys_clk) begin
    probe <= req ? {1'h1, isRd, addr, tag_r ^ {20'h0, flip[1], 3'h0, flip[0]}} :
      {1'h0, ~probe[59:0]};
  end
endmodule

// ===== verification/bus_error_capture_tb.sv
// Self-checking bench for the bus error capture block
`timescale 1ns/100ps
module bus_error_capture_tb;
  import bec_pkg::*;
  logic sys_clk, rst, req, isRd, cycleDone, fillErr, fillEccMulti, revLater, statusClr;
  logic tagWrEn, regWr, regRd, regRdValid, ramWrEn, nes;
  logic [1:0] flip, ack;
  logic [3:0] cmd;
  logic [6:0] cc;
  logic [11:0] regAddr;
  logic [31:0] regWrData, regRdData, d;
  logic [33:0] pAddr, cycleAddr, ifAddr;
  logic [24:0] tagWrData, pTag, ramWrData, tg;
  bec_probe_t probe;
  bec_status_t st;
  int fails = 0, checks_done = 0, cyc = 0;
  bus_error_capture dut (.sys_clk, .rst, .probeIn(probe), .interfaceCommand(cmd), .cycleDone,
    .cycleAcknowledgePins(ack), .cycleAddr, .cycleCacheState(cc[6:4]),
    .cycleCommander(cc[3:0]),
    .fillErr, .fillEccMulti, .revLater, .statusClr, .tagWrEn, .tagWrData, .regAddr, .regWr,
    .regRd, .regWrData, .regRdData, .regRdValid, .interfaceStatus(st),
    .interfaceAddress(ifAddr), .probeResultTag(pTag), .tagRamWrEn(ramWrEn),
    .tagRamWrData(ramWrData), .nodeErrorSummary(nes));
  bec_bus_model far (.sys_clk, .req, .isRd, .addr(pAddr), .flip, .ramWrEn, .ramWrData, .probe);
  // 100 MHz clock
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Hang guard, far above the roughly 130 cycles needed
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      wrap_up;
    end
  end
  task automatic chk(input string n, input logic [33:0] got, input logic [33:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge sys_clk);
    {regRd, regAddr} <= {1'h1, a};
    @(posedge sys_clk);
    regRd <= 1'h0;
    #1;
    d = regRdData;
    chk("regRdValid", regRdValid, 1'h1);
  endtask
  // Probe answered by the tag RAM model; results settle three edges on
  task automatic prb(input logic r, input logic [1:0] f, input logic [3:0] c, input logic [33:0] a);
    @(posedge sys_clk);
    {req, isRd, flip, cmd, pAddr} <= {1'h1, r, f, c, a};
    @(posedge sys_clk);
    req <= 1'h0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task automatic hard(input logic [33:0] a, input logic [6:0] c);
    @(posedge sys_clk);
    {cycleDone, ack, cycleAddr, cc} <= {1'h1, 2'h1, a, c};
    @(posedge sys_clk);
    {cycleDone, ack} <= 3'h3;
    #1;
  endtask
  // Unlock and write-one-clear the module error register, then the summary bit
  task automatic clr;
    @(posedge sys_clk);
    {statusClr, regWr, regAddr, regWrData} <= {2'h3, 12'hC40, 32'h7FF};
    @(posedge sys_clk);
    {statusClr, regAddr, regWrData} <= {1'h0, 12'h040, 32'h1};
    @(posedge sys_clk);
    regWr <= 1'h0;
    rd(12'hC40);
    chk("cleared", d, 32'h0);
  endtask
  task automatic t_par;
    @(posedge sys_clk);
    {tagWrEn, tagWrData} <= {1'h1, tg};
    @(posedge sys_clk);
    tagWrEn <= 1'h0;
    prb(1'h1, 2'h0, 4'h0, 34'h1);
    chk("clean", st, 9'h0);
    for (int i = 0; i < 4; i++) begin
      prb(i[0], i[1] ? 2'h2 : 2'h1, 4'h7, 34'h200000100 + 34'(i));
      chk("status", st, 34'h1 << ((i[1] ? 0 : 2) + (i[0] ? 0 : 1)));
      chk("address", ifAddr, 34'h200000100 + 34'(i));
      chk("tag", pTag, tg ^ {i[1], 3'h0, !i[1]});
      rd(12'h040);
      chk("summary", d, 32'h1);
      chk("summary pin", nes, 1'h1);
      rd(12'hC40);
      chk("source", d, i[1] ? 32'h1 : 32'h2);
      clr;
    end
    $display("parity test done");
  endtask
  task automatic t_lock;
    hard(34'h300000040, 7'h5A);
    rd(12'h740);
    chk("capture", d, 32'h5A);
    prb(1'h0, 2'h1, 4'h2, 34'h1234);
    chk("status", st, 9'h050);
    chk("address", ifAddr, 34'h300000040);
    clr;
    prb(1'h1, 2'h2, 4'h0, 34'h77);
    hard(34'h88, 7'h23);
    prb(1'h1, 2'h1, 4'h0, 34'h99);
    chk("status", st, 9'h041);
    chk("address", ifAddr, 34'h77);
    chk("tag", pTag, tg ^ 25'h10);
    rd(12'hC40);
    chk("source", d, 32'h41);
    // Hard error under lock must not overwrite the command capture
    rd(12'h740);
    chk("capture held", d, 32'h5A);
    clr;
    $display("lock test done");
  endtask
  task automatic t_misc;
    prb(1'h1, 2'h2, 4'h9, 34'h5);
    chk("inconsistent", st.inconsistent, 1'h1);
    rd(12'hC40);
    chk("source", d[10], 1'h1);
    chk("source all", d, 32'h401);
    clr;
    // A cycle ending with a non-hard acknowledge records nothing
    @(posedge sys_clk);
    {cycleDone, ack} <= 3'h6;
    @(posedge sys_clk);
    cycleDone <= 1'h0;
    #1;
    chk("soft ack", st, 9'h0);
    // Two fills in the earlier revision, then one multi-bit fill in the later
    for (int k = 0; k < 3; k++) begin
      @(posedge sys_clk);
      {revLater, fillErr, fillEccMulti} <= {k == 2, k < 2, k == 2};
      @(posedge sys_clk);
      {fillErr, fillEccMulti} <= 2'h0;
      #1;
      chk("fill second", st.fillSecond, k != 0);
      if (k == 1) clr;
    end
    rd(12'h100);
    chk("unmapped", d, 32'h0);
    $display("misc test done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    {rst, req, isRd, cycleDone, fillErr, fillEccMulti, revLater, statusClr, tagWrEn} = 9'h100;
    {regWr, regRd, flip, ack, cmd, regAddr, regWrData, pAddr, cycleAddr, tagWrData, cc} = '0;
    tg = {20'h5A3C1, ^20'h5A3C1, 3'h6, ^3'h6};
    repeat (8) @(posedge sys_clk);
    rst <= 1'h0;
    t_par;
    t_lock;
    t_misc;
    wrap_up;
  end
endmodule
